// File: src/scf_consts.vh
// Constants for the SPI card response and data token framer
`ifndef SCF_CONSTS_VH
`define SCF_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------
`define SCF_OFS_CTRL        4'h0
`define SCF_OFS_OPCOND      4'h4
`define SCF_OFS_STATUS      4'h8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCF_RST_BLOCK_LEN   12'h200
`define SCF_RST_OPCOND      32'h00ff8000

// ----------------------------------------------------------------
// Transmit request kinds
// ----------------------------------------------------------------
`define SCF_KIND_R1         3'h0
`define SCF_KIND_R1B        3'h1
`define SCF_KIND_R2         3'h2
`define SCF_KIND_R3         3'h3
`define SCF_KIND_DRESP      3'h4
`define SCF_KIND_DERR       3'h5
`define SCF_KIND_DATA       3'h6

// ----------------------------------------------------------------
// Token bytes and acknowledge codes
// ----------------------------------------------------------------
`define SCF_TOK_START       8'hfe
`define SCF_TOK_START_MULTI 8'hfc
`define SCF_TOK_STOP        8'hfd
`define SCF_BYTE_IDLE       8'hff
`define SCF_BYTE_BUSY       8'h00
`define SCF_ACK_ACCEPTED    3'h2
`define SCF_ACK_CRC_ERR     3'h5
`define SCF_ACK_WRITE_ERR   3'h6

// ----------------------------------------------------------------
// Sticky flag positions in the 15-bit flag vector
// ----------------------------------------------------------------
`define SCF_F_PARAM         0
`define SCF_F_ADDR          1
`define SCF_F_ERSEQ         2
`define SCF_F_COMCRC        3
`define SCF_F_ILLEGAL       4
`define SCF_F_ERRESET       5
`define SCF_F_RANGE         6
`define SCF_F_OVERWRITE     7
`define SCF_F_ERPARAM       8
`define SCF_F_WPVIOL        9
`define SCF_F_ECC           10
`define SCF_F_CTRLERR       11
`define SCF_F_GENERR        12
`define SCF_F_WPSKIP        13
`define SCF_F_LOCKFAIL      14
`define SCF_NFLAGS          15

// Flags cleared when the byte carrying them is sent
`define SCF_CLR_SHORT       15'h003f
`define SCF_CLR_SECOND      15'h7fc0
`define SCF_CLR_DERR        15'h1c40

`endif

// File: src/scf_framer.v
// Device-side SPI response and data token framer with status flag store
`timescale 1ns/10ps
`include "scf_consts.vh"

module scf_framer (
    input  wire        core_clk,
    input  wire        reset_n,
    // SPI pins
    input  wire        spi_clk,
    input  wire        spi_cs_n,
    input  wire        spi_mosi,
    output wire        spi_miso,
    output wire        spi_miso_oe_n,
    // Register port
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output wire [31:0] reg_rdata,
    // Transmit requests from the card core
    input  wire        tx_req,
    input  wire [2:0]  tx_kind,
    input  wire [2:0]  tx_ack_code,
    input  wire [15:0] tx_crc,
    output wire        tx_ready,
    input  wire [7:0]  tx_data,
    output wire        tx_data_take,
    // Card state and events
    input  wire [14:0] flag_set,
    input  wire        card_busy,
    input  wire        card_locked,
    input  wire        reset_cmd,
    input  wire        init_done,
    // Received data token stream
    output wire [7:0]  rx_byte,
    output wire        rx_byte_valid,
    output wire        rx_byte_is_crc,
    output wire        rx_block_start,
    output wire        rx_block_multi,
    output wire        rx_stop
);

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    reg [2:0] sclk_q;
    reg [1:0] cs_q;
    reg [1:0] mosi_q;
    reg       cs_act_d1_q;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_q      <= 3'h0;
            cs_q        <= 2'h3;
            mosi_q      <= 2'h3;
            cs_act_d1_q <= 1'b0;
        end else begin
            sclk_q      <= {sclk_q[1:0], spi_clk};
            cs_q        <= {cs_q[0], spi_cs_n};
            mosi_q      <= {mosi_q[0], spi_mosi};
            cs_act_d1_q <= ~cs_q[1];
        end
    end

    wire cs_act  = ~cs_q[1];
    wire cs_fall = cs_act & ~cs_act_d1_q;
    wire sclk_rise = cs_act & sclk_q[1] & ~sclk_q[2];
    wire sclk_fall = cs_act & ~sclk_q[1] & sclk_q[2];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [11:0] blen_q;
    reg [31:0] opcond_q;
    reg [31:0] rdata_q;
    reg [14:0] flag_q;
    reg        idle_q;
    reg        active_q;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            blen_q   <= `SCF_RST_BLOCK_LEN;
            opcond_q <= `SCF_RST_OPCOND;
        end else if (reg_wr) begin
            if (reg_addr == `SCF_OFS_CTRL) begin
                blen_q <= reg_wdata[11:0];
            end else if (reg_addr == `SCF_OFS_OPCOND) begin
                opcond_q <= reg_wdata;
            end
        end
    end

    // Status reads here do not clear flags; only the host link does
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 32'h0;
        end else if (reg_rd) begin
            if (reg_addr == `SCF_OFS_CTRL) begin
                rdata_q <= {20'h0, blen_q};
            end else if (reg_addr == `SCF_OFS_OPCOND) begin
                rdata_q <= opcond_q;
            end else if (reg_addr == `SCF_OFS_STATUS) begin
                rdata_q <= {13'h0, active_q, card_locked, idle_q, 1'b0, flag_q};
            end else begin
                rdata_q <= 32'h0;
            end
        end else begin
            rdata_q <= 32'h0;
        end
    end

    assign reg_rdata = rdata_q;

    // ----------------------------------------------------------------
    // Status bytes
    // ----------------------------------------------------------------
    // No underrun or overrun flag exists in this flag set
    wire [7:0] short_byte = {1'b0,
                             flag_q[`SCF_F_PARAM], flag_q[`SCF_F_ADDR],
                             flag_q[`SCF_F_ERSEQ], flag_q[`SCF_F_COMCRC],
                             flag_q[`SCF_F_ILLEGAL], flag_q[`SCF_F_ERRESET],
                             idle_q};
    wire [7:0] second_byte = {flag_q[`SCF_F_RANGE] | flag_q[`SCF_F_OVERWRITE],
                              flag_q[`SCF_F_ERPARAM], flag_q[`SCF_F_WPVIOL],
                              flag_q[`SCF_F_ECC], flag_q[`SCF_F_CTRLERR],
                              flag_q[`SCF_F_GENERR],
                              flag_q[`SCF_F_WPSKIP] | flag_q[`SCF_F_LOCKFAIL],
                              card_locked};
    wire [7:0] derr_byte = {4'h0, flag_q[`SCF_F_RANGE], flag_q[`SCF_F_ECC],
                            flag_q[`SCF_F_CTRLERR], flag_q[`SCF_F_GENERR]};

    // ----------------------------------------------------------------
    // Transmit sequencer
    // ----------------------------------------------------------------
    reg [2:0]  kind_q;
    reg [2:0]  ack_q;
    reg [15:0] crc_q;
    reg [12:0] idx_q;
    reg [7:0]  sr_q;
    reg [2:0]  bit_q;
    reg        oe_n_q;

    reg [7:0]  nb;
    reg        nb_last;
    reg        nb_take;
    reg [14:0] nb_clr;

    wire [12:0] blen_w = {1'b0, blen_q};

    always @* begin
        nb      = `SCF_BYTE_IDLE;
        nb_last = 1'b1;
        nb_take = 1'b0;
        nb_clr  = 15'h0;
        if (active_q) begin
            if (idx_q == 13'h0 && kind_q <= `SCF_KIND_R3) begin
                nb      = short_byte;
                nb_clr  = `SCF_CLR_SHORT;
                nb_last = (kind_q == `SCF_KIND_R1);
            end else begin
                case (kind_q)
                    `SCF_KIND_R1B: begin
                        nb      = card_busy ? `SCF_BYTE_BUSY : `SCF_BYTE_IDLE;
                        nb_last = ~card_busy;
                    end
                    `SCF_KIND_R2: begin
                        nb     = second_byte;
                        nb_clr = `SCF_CLR_SECOND;
                    end
                    `SCF_KIND_R3: begin
                        case (idx_q[2:0])
                            3'h1: nb = opcond_q[31:24];
                            3'h2: nb = opcond_q[23:16];
                            3'h3: nb = opcond_q[15:8];
                            default: nb = opcond_q[7:0];
                        endcase
                        nb_last = (idx_q == 13'h4);
                    end
                    `SCF_KIND_DRESP: begin
                        nb = {4'h0, ack_q, 1'b1};
                    end
                    `SCF_KIND_DERR: begin
                        nb     = derr_byte;
                        nb_clr = `SCF_CLR_DERR;
                    end
                    `SCF_KIND_DATA: begin
                        nb_last = 1'b0;
                        if (idx_q == 13'h0) begin
                            nb = `SCF_TOK_START;
                        end else if (idx_q <= blen_w) begin
                            nb      = tx_data;
                            nb_take = 1'b1;
                        end else if (idx_q == blen_w + 13'h1) begin
                            nb = crc_q[15:8];
                        end else begin
                            nb      = crc_q[7:0];
                            nb_last = 1'b1;
                        end
                    end
                    default: begin
                        nb = `SCF_BYTE_IDLE;
                    end
                endcase
            end
        end
    end

    // A byte is loaded when the chip select falls or after the eighth bit
    wire load_ev = cs_fall | (sclk_fall & (bit_q == 3'h7));

    assign tx_ready     = ~active_q;
    assign tx_data_take = load_ev & nb_take;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            active_q <= 1'b0;
            kind_q   <= `SCF_KIND_R1;
            ack_q    <= `SCF_ACK_ACCEPTED;
            crc_q    <= 16'h0;
            idx_q    <= 13'h0;
        end else if (!active_q) begin
            if (tx_req) begin
                active_q <= 1'b1;
                kind_q   <= tx_kind;
                ack_q    <= tx_ack_code;
                crc_q    <= tx_crc;
                idx_q    <= 13'h0;
            end
        end else if (load_ev) begin
            if (nb_last) begin
                active_q <= 1'b0;
            // Saturate so an endless busy wait never wraps back to the status byte
            end else if (idx_q != 13'h1fff) begin
                idx_q <= idx_q + 13'h1;
            end
        end
    end

    // Mode 0: output changes on falling clock, sampled by host on rising
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sr_q   <= `SCF_BYTE_IDLE;
            bit_q  <= 3'h0;
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= ~cs_act;
            if (!cs_act) begin
                sr_q  <= `SCF_BYTE_IDLE;
                bit_q <= 3'h0;
            end else if (load_ev) begin
                sr_q  <= nb;
                bit_q <= 3'h0;
            end else if (sclk_fall) begin
                sr_q  <= {sr_q[6:0], 1'b1};
                bit_q <= bit_q + 3'h1;
            end
        end
    end

    assign spi_miso      = sr_q[7];
    assign spi_miso_oe_n = oe_n_q;

    // ----------------------------------------------------------------
    // Sticky flags and idle state
    // ----------------------------------------------------------------
    // Set wins over a clear in the same cycle
    wire [14:0] flag_clr = (active_q & load_ev) ? nb_clr : 15'h0;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_q <= 15'h0;
            idle_q <= 1'b1;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | flag_set;
            if (reset_cmd) begin
                idle_q <= 1'b1;
            end else if (init_done) begin
                idle_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive side: data tokens from the host
    // ----------------------------------------------------------------
    reg [7:0]  rx_sr_q;
    reg [2:0]  rx_bit_q;
    reg [12:0] rx_left_q;
    reg [7:0]  rx_byte_q;
    reg        rx_valid_q;
    reg        rx_crc_q;
    reg        rx_start_q;
    reg        rx_multi_q;
    reg        rx_stop_q;

    wire [7:0] rx_full = {rx_sr_q[6:0], mosi_q[1]};
    wire       rx_done = sclk_rise & (rx_bit_q == 3'h7);

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_sr_q    <= 8'h0;
            rx_bit_q   <= 3'h0;
            rx_left_q  <= 13'h0;
            rx_byte_q  <= 8'h0;
            rx_valid_q <= 1'b0;
            rx_crc_q   <= 1'b0;
            rx_start_q <= 1'b0;
            rx_multi_q <= 1'b0;
            rx_stop_q  <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            rx_start_q <= 1'b0;
            rx_stop_q  <= 1'b0;
            if (!cs_act) begin
                rx_bit_q <= 3'h0;
            end else if (sclk_rise) begin
                rx_sr_q  <= rx_full;
                rx_bit_q <= rx_bit_q + 3'h1;
            end
            if (rx_done) begin
                if (rx_left_q != 13'h0) begin
                    rx_byte_q  <= rx_full;
                    rx_valid_q <= 1'b1;
                    rx_crc_q   <= (rx_left_q <= 13'h2);
                    rx_left_q  <= rx_left_q - 13'h1;
                end else if (rx_full == `SCF_TOK_START ||
                             rx_full == `SCF_TOK_START_MULTI) begin
                    rx_start_q <= 1'b1;
                    rx_multi_q <= (rx_full == `SCF_TOK_START_MULTI);
                    rx_left_q  <= blen_w + 13'h2;
                end else if (rx_full == `SCF_TOK_STOP) begin
                    rx_stop_q  <= 1'b1;
                    rx_multi_q <= 1'b0;
                end
            end
        end
    end

    assign rx_byte        = rx_byte_q;
    assign rx_byte_valid  = rx_valid_q;
    assign rx_byte_is_crc = rx_crc_q;
    assign rx_block_start = rx_start_q;
    assign rx_block_multi = rx_multi_q;
    assign rx_stop        = rx_stop_q;

endmodule

// File: testbench/scf_framer_props.sv
// Port-level timing checker for the SPI token framer
`timescale 1ns/10ps
module scf_framer_props (
    input wire        core_clk,
    input wire        reset_n,
    input wire        spi_cs_n,
    input wire        spi_miso_oe_n,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire        tx_req,
    input wire        tx_ready,
    input wire        tx_data_take,
    input wire        rx_byte_valid,
    input wire        rx_block_start,
    input wire        rx_block_multi,
    input wire        rx_stop
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_take;
        tx_req && tx_ready;
    endsequence
    // Allows for the select synchroniser lag
    sequence s_cs_idle;
        spi_cs_n [*5];
    endsequence
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside the read answer");
    a_cs_release: assert property (s_cs_idle |-> spi_miso_oe_n)
        else $error("data out driven while deselected");
    a_take_drops: assert property (s_take |=> !tx_ready)
        else $error("ready stayed high after a taken request");
    a_ready_cause: assert property ($fell(tx_ready) |-> $past(tx_req))
        else $error("ready fell without a request");
    a_take_busy: assert property (tx_data_take |-> !tx_ready)
        else $error("data taken while idle");
    a_take_single: assert property (tx_data_take |=> !tx_data_take)
        else $error("data take longer than one cycle");
    a_rx_single: assert property (rx_byte_valid |=> !rx_byte_valid)
        else $error("received byte pulse longer than one cycle");
    a_start_not_data: assert property (rx_block_start |-> !rx_byte_valid)
        else $error("start byte delivered as data");
    a_stop_ends: assert property (rx_stop |=> !rx_block_multi)
        else $error("multi block flag kept after stop");
    a_multi_cause: assert property ($rose(rx_block_multi)
        |-> (rx_block_start || $past(rx_block_start)))
        else $error("multi block flag rose without a start byte");
endmodule

bind scf_framer scf_framer_props u_scf_framer_props (
    .core_clk(core_clk), .reset_n(reset_n), .spi_cs_n(spi_cs_n),
    .spi_miso_oe_n(spi_miso_oe_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_req(tx_req), .tx_ready(tx_ready), .tx_data_take(tx_data_take),
    .rx_byte_valid(rx_byte_valid), .rx_block_start(rx_block_start),
    .rx_block_multi(rx_block_multi), .rx_stop(rx_stop)
);

// File: testbench/scf_host.sv
// Behavioural SPI mode 0 host driving clock, select and data
`timescale 1ns/10ps
module scf_host (
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input  wire  spi_miso,
    input  wire  spi_miso_oe_n
);
    // ------------------------------------------------------------
    // Frame control and byte exchange
    // ------------------------------------------------------------
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b1;
    end
    // Clock stands still outside frames; data line toggles when unused
    task automatic sel(input logic on);
        #100;
        spi_cs_n = ~on;
        if (!on)
            spi_mosi = ~spi_mosi;
        #100;
    endtask
    // 64 ns bit period; a released data out line floats high on its pull-up
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = tx[i];
            #32;
            spi_clk = 1'b1;
            rx[i] = spi_miso_oe_n ? 1'b1 : spi_miso;
            #32;
            spi_clk = 1'b0;
        end
    endtask
endmodule

// File: testbench/spi_card_response_token_framer_test.sv
// Self-checking bench for the SPI response and data token framer
`timescale 1ns/10ps
`include "scf_consts.vh"
module spi_card_response_token_framer_test;
    logic        core_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        tx_req = 1'b0, card_busy = 1'b0, card_locked = 1'b0;
    logic        reset_cmd = 1'b0, init_done = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [2:0]  tx_kind = 3'h0, tx_ack_code = 3'h0;
    logic [15:0] tx_crc = 16'hbeef;
    logic [7:0]  tx_data = 8'ha1, got;
    logic [14:0] flag_set = 15'h0;
    logic [7:0]  exp_q[$], rx_q[$];
    logic        crc_q[$];
    wire         spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n, tx_ready, tx_data_take;
    wire         rx_byte_valid, rx_byte_is_crc, rx_block_start, rx_block_multi, rx_stop;
    wire [31:0]  reg_rdata;
    wire [7:0]   rx_byte;
    int          err_total = 0, cmp_count = 0, cyc = 0, n_start = 0, n_stop = 0;

    always #2.5 core_clk = ~core_clk;

    scf_framer u_scf_framer (
        .core_clk(core_clk), .reset_n(reset_n), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_req(tx_req), .tx_kind(tx_kind), .tx_ack_code(tx_ack_code),
        .tx_crc(tx_crc), .tx_ready(tx_ready), .tx_data(tx_data), .tx_data_take(tx_data_take),
        .flag_set(flag_set), .card_busy(card_busy), .card_locked(card_locked),
        .reset_cmd(reset_cmd), .init_done(init_done), .rx_byte(rx_byte),
        .rx_byte_valid(rx_byte_valid), .rx_byte_is_crc(rx_byte_is_crc),
        .rx_block_start(rx_block_start), .rx_block_multi(rx_block_multi), .rx_stop(rx_stop)
    );
    scf_host u_scf_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n));

    // ------------------------------------------------------------
    // Data feed, receive monitor and hang guard
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc++;
        if (tx_data_take === 1'b1)
            tx_data <= tx_data + 8'h11;
        if (rx_byte_valid === 1'b1) begin
            rx_q.push_back(rx_byte);
            crc_q.push_back(rx_byte_is_crc);
        end
        if (rx_block_start === 1'b1)
            n_start++;
        if (rx_stop === 1'b1)
            n_stop++;
        if (cyc == 20000) begin
            err_total++;
            $display("[ERR] %0t run did not finish", $time);
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic set_flags(input logic [14:0] f);
        @(posedge core_clk);
        flag_set <= f;
        @(posedge core_clk);
        flag_set <= 15'h0;
    endtask
    task automatic request(input logic [2:0] k, input logic [2:0] c);
        @(posedge core_clk);
        tx_kind <= k;
        tx_ack_code <= c;
        tx_req <= 1'b1;
        @(posedge core_clk);
        tx_req <= 1'b0;
    endtask
    task automatic read_bytes();
        if (spi_cs_n === 1'b1)
            u_scf_host.sel(1'b1);
        foreach (exp_q[i]) begin
            u_scf_host.xfer(8'hff, got);
            chk(got, exp_q[i]);
        end
    endtask
    task automatic token(input logic [2:0] k, input logic [2:0] c);
        request(k, c);
        read_bytes();
        u_scf_host.sel(1'b0);
        chk(tx_ready, 1'b1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        reg_read(`SCF_OFS_CTRL, `SCF_RST_BLOCK_LEN);
        reg_read(`SCF_OFS_OPCOND, `SCF_RST_OPCOND);
        reg_read(`SCF_OFS_STATUS, 32'h10000);
        reg_write(`SCF_OFS_STATUS, 32'hffffffff);
        reg_read(`SCF_OFS_STATUS, 32'h10000);
        reg_read(4'hc, 32'h0);
        reg_write(`SCF_OFS_CTRL, 32'h4);
        reg_read(`SCF_OFS_CTRL, 32'h4);
        $display("registers test done");
    endtask
    task automatic t_status();
        set_flags(15'h003f);
        exp_q = '{8'h7f};
        token(`SCF_KIND_R1, 3'h0);
        exp_q = '{8'h01};
        token(`SCF_KIND_R1, 3'h0);
        @(posedge core_clk);
        card_locked <= 1'b1;
        set_flags(15'h1542);
        exp_q = '{8'h21, 8'hd5};
        token(`SCF_KIND_R2, 3'h0);
        set_flags(15'h4a80);
        exp_q = '{8'h01, 8'hab};
        token(`SCF_KIND_R2, 3'h0);
        @(posedge core_clk);
        card_locked <= 1'b0;
        set_flags(15'h2000);
        exp_q = '{8'h01, 8'h02};
        token(`SCF_KIND_R2, 3'h0);
        reg_read(`SCF_OFS_STATUS, 32'h10000);
        $display("status test done");
    endtask
    task automatic t_opcond_busy();
        reg_write(`SCF_OFS_OPCOND, 32'h12345678);
        exp_q = '{8'h01, 8'h12, 8'h34, 8'h56, 8'h78};
        token(`SCF_KIND_R3, 3'h0);
        @(posedge core_clk);
        card_busy <= 1'b1;
        exp_q = '{8'h01, 8'h00, 8'h00};
        request(`SCF_KIND_R1B, 3'h0);
        read_bytes();
        @(posedge core_clk);
        card_busy <= 1'b0;
        for (int i = 0; i < 3 && got === 8'h00; i++)
            u_scf_host.xfer(8'hff, got);
        chk(got, 8'hff);
        u_scf_host.sel(1'b0);
        $display("op conditions and busy test done");
    endtask
    task automatic t_ack_err();
        logic [2:0] codes[3] = '{3'b010, 3'b101, 3'b110};
        foreach (codes[i]) begin
            exp_q = '{{4'h0, codes[i], 1'b1}};
            token(`SCF_KIND_DRESP, codes[i]);
        end
        set_flags(15'h0840);
        reg_read(`SCF_OFS_STATUS, 32'h10840);
        exp_q = '{8'h0a};
        token(`SCF_KIND_DERR, 3'h0);
        set_flags(15'h1400);
        exp_q = '{8'h05};
        token(`SCF_KIND_DERR, 3'h0);
        reg_read(`SCF_OFS_STATUS, 32'h10000);
        $display("acknowledge and error token test done");
    endtask
    task automatic t_data();
        logic [7:0] s[9] = '{8'hff, 8'hfc, 8'h11, 8'h22, 8'h33, 8'h44, 8'h5a, 8'ha5, 8'hfd};
        exp_q = '{8'hfe, 8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'hbe, 8'hef};
        token(`SCF_KIND_DATA, 3'h0);
        u_scf_host.sel(1'b1);
        foreach (s[i]) begin
            u_scf_host.xfer(s[i], got);
            if (i == 7)
                chk(rx_block_multi, 1'b1);
        end
        u_scf_host.sel(1'b0);
        chk(rx_q.size(), 6);
        foreach (rx_q[i])
            chk({crc_q[i], rx_q[i]}, {i > 3, s[i + 2]});
        chk(n_start, 1);
        chk(n_stop, 1);
        chk(rx_block_multi, 1'b0);
        $display("data token test done");
    endtask
    task automatic t_idle();
        @(posedge core_clk);
        init_done <= 1'b1;
        @(posedge core_clk);
        init_done <= 1'b0;
        exp_q = '{8'h00};
        token(`SCF_KIND_R1, 3'h0);
        @(posedge core_clk);
        reset_cmd <= 1'b1;
        @(posedge core_clk);
        reset_cmd <= 1'b0;
        exp_q = '{8'h01};
        token(`SCF_KIND_R1, 3'h0);
        $display("idle test done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        t_regs();
        t_status();
        t_opcond_busy();
        t_ack_err();
        t_data();
        t_idle();
        report_and_stop();
    end
endmodule
